/* File: hdl/ucp_pkg.sv */
// Constants and pin bundles for the cell-side port
package ucp_pkg;

    // Cell and buffer geometry
    localparam int         CELL_BYTES   = 53;
    localparam int         FIFO_CELLS   = 3;
    localparam int         FIFO_BYTES   = CELL_BYTES * FIFO_CELLS;
    localparam logic [7:0] CELL_LAST    = 8'h34;
    localparam logic [7:0] FIFO_LAST    = 8'h9E;
    localparam logic [7:0] FIFO_SIZE    = 8'h9F;
    localparam logic [7:0] TX_CLAV_MAX  = 8'h6A;   // Used bytes leaving room for one cell
    localparam logic [7:0] PTR_ZERO     = 8'h00;
    localparam logic [7:0] PTR_ONE      = 8'h01;
    localparam logic [1:0] CELLS_NONE   = 2'h0;
    localparam logic [1:0] CELLS_ONE    = 2'h1;

    // Receive pins driven by the port
    typedef struct packed {
        logic       soc;
        logic       parity;
        logic [7:0] data;
    } ucp_rx_pins_t;

    // Transmit pins driven by the cell-layer device
    typedef struct packed {
        logic       en_n;
        logic       soc;
        logic       parity;
        logic [7:0] data;
    } ucp_tx_pins_t;

    // Byte toward the line side, with its start-of-cell mark
    typedef struct packed {
        logic       soc;
        logic [7:0] data;
    } ucp_byte_t;

endpackage : ucp_pkg

/* File: hdl/ucp_cell_port.sv */
// Cell-side octet port: receive and transmit cell buffers with link-clock sampling
//
// Operation
// - Receive cell-available high when full cell buffered
// - Transmit cell-available high when one cell fits
// - Received cells leave as bytes on data bus
// - Receive parity makes each byte odd
// - Receive start-of-cell only with first byte
// - Both directions run from core_clk, each timed by its own sampled link clock
// - Check transmit odd parity, flag when enabled
// - Every cell is fifty-three bytes long
// - Stop receive filling while signal is bad
`timescale 1ns/1ps

module ucp_cell_port (
    input  wire  logic                  core_clk,
    input  wire  logic                  rst,
    input  wire  logic                  rx_clk_pin,
    input  wire  logic                  rx_en_n,
    output ucp_pkg::ucp_rx_pins_t       rx_out,
    output logic                        rx_clav,
    input  wire  logic                  tx_clk_pin,
    input  wire  ucp_pkg::ucp_tx_pins_t tx_in,
    output logic                        tx_clav,
    input  wire  logic                  good_signal,
    input  wire  logic                  par_check_en,
    input  wire  logic                  line_rx_valid,
    input  wire  logic [7:0]            line_rx_data,
    output logic                        line_rx_ready,
    output logic                        line_tx_valid,
    output ucp_pkg::ucp_byte_t          line_tx_byte,
    input  wire  logic                  line_tx_ready,
    output logic                        tx_par_err
);

    // Wrapping buffer pointer step
    function automatic logic [7:0] ptr_inc(input logic [7:0] p);
        ptr_inc = (p == ucp_pkg::FIFO_LAST) ? ucp_pkg::PTR_ZERO : p + ucp_pkg::PTR_ONE;
    endfunction : ptr_inc

    // Byte position inside a cell
    function automatic logic [7:0] pos_inc(input logic [7:0] p);
        pos_inc = (p == ucp_pkg::CELL_LAST) ? ucp_pkg::PTR_ZERO : p + ucp_pkg::PTR_ONE;
    endfunction : pos_inc

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic                  rxc_s1_q, rxc_s2_q, rxc_s3_q;
    logic                  txc_s1_q, txc_s2_q, txc_s3_q;
    logic                  rxen_s1_q, rxen_s2_q;
    ucp_pkg::ucp_tx_pins_t txb_s1_q, txb_s2_q;
    logic                  rx_rise, rx_fall, tx_fall;

    // Link clocks are slow (80 ns) so two flops plus a history flop find edges
    always_ff @(posedge core_clk) begin
        rxc_s1_q  <= rx_clk_pin;
        rxc_s2_q  <= rxc_s1_q;
        rxc_s3_q  <= rxc_s2_q;
        txc_s1_q  <= tx_clk_pin;
        txc_s2_q  <= txc_s1_q;
        txc_s3_q  <= txc_s2_q;
        rxen_s1_q <= rx_en_n;
        rxen_s2_q <= rxen_s1_q;
        txb_s1_q  <= tx_in;
        txb_s2_q  <= txb_s1_q;
    end

    // Edges of the synced link clocks; rising edges move outputs, falling ones sample
    assign rx_rise = rxc_s2_q & ~rxc_s3_q;
    assign rx_fall = ~rxc_s2_q & rxc_s3_q;
    assign tx_fall = ~txc_s2_q & txc_s3_q;

    ////////////////////////////////////////////////////////////////////////////
    // Receive direction

    logic [7:0]            rx_mem_q [ucp_pkg::FIFO_BYTES];
    logic [7:0]            rx_wptr_q, rx_wptr_d, rx_rptr_q, rx_rptr_d;
    logic [7:0]            rx_used_q, rx_used_d, rx_wpos_q, rx_wpos_d;
    logic [7:0]            rx_rpos_q, rx_rpos_d;
    logic [1:0]            rx_cells_q, rx_cells_d;
    logic                  rx_vld_q, rx_vld_d, rx_encap_q, rx_encap_d;
    ucp_pkg::ucp_rx_pins_t rx_out_q, rx_out_d;
    logic                  rx_wr, rx_take, rx_load, rx_drop, rx_done;
    logic [7:0]            rx_head;

    assign line_rx_ready = good_signal && (rx_used_q != ucp_pkg::FIFO_SIZE);
    assign rx_wr         = line_rx_valid && line_rx_ready;
    assign rx_done       = rx_wr && (rx_wpos_q == ucp_pkg::CELL_LAST);
    assign rx_drop       = !good_signal && (rx_wpos_q != ucp_pkg::PTR_ZERO);
    // Enable was caught half a period early, so it is the one the far end sampled
    assign rx_take       = rx_rise && !rx_encap_q && rx_vld_q;
    // A cell is only begun once it is complete, so its later bytes never run dry
    assign rx_load       = rx_rise && (rx_take || !rx_vld_q)
                           && ((rx_cells_q != ucp_pkg::CELLS_NONE)
                               || (rx_rpos_q != ucp_pkg::PTR_ZERO));
    assign rx_head       = rx_mem_q[rx_rptr_q];
    assign rx_clav       = (rx_cells_q != ucp_pkg::CELLS_NONE);
    assign rx_out        = rx_out_q;

    // Next state of the receive side
    always_comb begin
        rx_wptr_d  = rx_wptr_q;
        rx_wpos_d  = rx_wpos_q;
        rx_rptr_d  = rx_rptr_q;
        rx_rpos_d  = rx_rpos_q;
        rx_cells_d = rx_cells_q;
        rx_vld_d   = rx_vld_q;
        rx_out_d   = rx_out_q;
        rx_used_d  = rx_used_q + 8'(rx_wr) - 8'(rx_load);
        rx_encap_d = rx_fall ? rxen_s2_q : rx_encap_q;
        if (rx_drop) begin
            // Lost signal: the partial cell is rewound, never handed on
            rx_wptr_d = rx_wptr_q - rx_wpos_q;
            if (rx_wptr_q < rx_wpos_q) begin
                rx_wptr_d = rx_wptr_q + ucp_pkg::FIFO_SIZE - rx_wpos_q;
            end
            rx_wpos_d = ucp_pkg::PTR_ZERO;
            rx_used_d = rx_used_q - rx_wpos_q - 8'(rx_load);
        end else if (rx_wr) begin
            rx_wptr_d = ptr_inc(rx_wptr_q);
            rx_wpos_d = pos_inc(rx_wpos_q);
        end
        if (rx_load) begin
            rx_rptr_d       = ptr_inc(rx_rptr_q);
            rx_rpos_d       = pos_inc(rx_rpos_q);
            rx_vld_d        = 1'b1;
            rx_out_d.data   = rx_head;
            rx_out_d.parity = ~^rx_head;
            rx_out_d.soc    = (rx_rpos_q == ucp_pkg::PTR_ZERO);
        end else if (rx_take) begin
            rx_vld_d     = 1'b0;
            rx_out_d.soc = 1'b0;
        end
        rx_cells_d = rx_cells_q + 2'(rx_done)
                     - ((rx_load && rx_rpos_q == ucp_pkg::PTR_ZERO) ? ucp_pkg::CELLS_ONE
                                                                    : ucp_pkg::CELLS_NONE);
    end

    // Receive registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_wptr_q  <= ucp_pkg::PTR_ZERO;
            rx_wpos_q  <= ucp_pkg::PTR_ZERO;
            rx_rptr_q  <= ucp_pkg::PTR_ZERO;
            rx_rpos_q  <= ucp_pkg::PTR_ZERO;
            rx_used_q  <= ucp_pkg::PTR_ZERO;
            rx_cells_q <= ucp_pkg::CELLS_NONE;
            rx_vld_q   <= 1'b0;
            rx_encap_q <= 1'b1;
            rx_out_q   <= '{soc: 1'b0, parity: 1'b1, data: ucp_pkg::PTR_ZERO};
        end else begin
            rx_wptr_q  <= rx_wptr_d;
            rx_wpos_q  <= rx_wpos_d;
            rx_rptr_q  <= rx_rptr_d;
            rx_rpos_q  <= rx_rpos_d;
            rx_used_q  <= rx_used_d;
            rx_cells_q <= rx_cells_d;
            rx_vld_q   <= rx_vld_d;
            rx_encap_q <= rx_encap_d;
            rx_out_q   <= rx_out_d;
        end
    end

    // Receive byte storage
    always_ff @(posedge core_clk) begin
        if (rx_wr) begin
            rx_mem_q[rx_wptr_q] <= line_rx_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit direction

    ucp_pkg::ucp_byte_t tx_mem_q [ucp_pkg::FIFO_BYTES];
    logic [7:0]         tx_wptr_q, tx_wptr_d, tx_rptr_q, tx_rptr_d;
    logic [7:0]         tx_used_q, tx_used_d, tx_wpos_q, tx_wpos_d;
    logic               tx_err_q, tx_err_d;
    logic               tx_xfer, tx_wr, tx_rd;

    // Data is sampled at mid-period, where it is settled for the next rising edge
    assign tx_xfer       = tx_fall && !txb_s2_q.en_n;
    // The far end heeds cell-available; a byte past a full buffer is dropped
    assign tx_wr         = tx_xfer && (tx_used_q != ucp_pkg::FIFO_SIZE);
    assign tx_rd         = line_tx_valid && line_tx_ready;
    assign tx_clav       = (tx_used_q <= ucp_pkg::TX_CLAV_MAX);
    assign line_tx_valid = (tx_used_q != ucp_pkg::PTR_ZERO);
    assign line_tx_byte  = tx_mem_q[tx_rptr_q];
    assign tx_par_err    = tx_err_q;

    // Next state of the transmit side
    always_comb begin
        tx_wptr_d = tx_wr ? ptr_inc(tx_wptr_q) : tx_wptr_q;
        tx_rptr_d = tx_rd ? ptr_inc(tx_rptr_q) : tx_rptr_q;
        tx_used_d = tx_used_q + 8'(tx_wr) - 8'(tx_rd);
        tx_wpos_d = tx_wpos_q;
        if (tx_wr) begin
            // Start-of-cell realigns the byte count
            tx_wpos_d = txb_s2_q.soc ? ucp_pkg::PTR_ONE : pos_inc(tx_wpos_q);
        end
        // Parity only raises a flag; the byte is stored regardless
        tx_err_d = tx_xfer && par_check_en && !(^{txb_s2_q.parity, txb_s2_q.data});
    end

    // Transmit registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_wptr_q <= ucp_pkg::PTR_ZERO;
            tx_rptr_q <= ucp_pkg::PTR_ZERO;
            tx_used_q <= ucp_pkg::PTR_ZERO;
            tx_wpos_q <= ucp_pkg::PTR_ZERO;
            tx_err_q  <= 1'b0;
        end else begin
            tx_wptr_q <= tx_wptr_d;
            tx_rptr_q <= tx_rptr_d;
            tx_used_q <= tx_used_d;
            tx_wpos_q <= tx_wpos_d;
            tx_err_q  <= tx_err_d;
        end
    end

    // Transmit byte storage, start-of-cell kept beside each byte
    always_ff @(posedge core_clk) begin
        if (tx_wr) begin
            tx_mem_q[tx_wptr_q] <= '{soc: txb_s2_q.soc, data: txb_s2_q.data};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence seq_los_hold;
        !line_rx_ready ##1 (rx_wpos_q == ucp_pkg::PTR_ZERO);
    endsequence

    sequence seq_cell_end;
        rx_wr && (rx_wpos_q == ucp_pkg::CELL_LAST) && good_signal;
    endsequence

    AST_RX_CLAV: assert property (@(posedge core_clk) disable iff (rst)
        seq_cell_end |=> rx_clav) else $error("rx_clav low after full cell");
    AST_TX_CLAV: assert property (@(posedge core_clk) disable iff (rst)
        (tx_used_q > ucp_pkg::TX_CLAV_MAX) |-> !tx_clav) else $error("tx_clav without room");
    AST_RX_DATA: assert property (@(posedge core_clk) disable iff (rst)
        rx_load |=> (rx_out.data == $past(rx_head))) else $error("rx byte mismatch");
    AST_RX_PAR: assert property (@(posedge core_clk) disable iff (rst)
        rx_vld_q |-> (^{rx_out.parity, rx_out.data})) else $error("rx parity even");
    AST_RX_SOC: assert property (@(posedge core_clk) disable iff (rst)
        (rx_load && rx_rpos_q != ucp_pkg::PTR_ZERO) |=> !rx_out.soc)
        else $error("soc on middle byte");
    AST_RX_EDGE: assert property (@(posedge core_clk) disable iff (rst)
        !rx_rise |=> $stable(rx_out)) else $error("rx pins moved off edge");
    AST_TX_PERR: assert property (@(posedge core_clk) disable iff (rst)
        (tx_xfer && par_check_en && !(^{txb_s2_q.parity, txb_s2_q.data})) |=> tx_par_err)
        else $error("tx parity error missed");
    AST_PERR_OFF: assert property (@(posedge core_clk) disable iff (rst)
        !par_check_en |=> !tx_par_err) else $error("parity flag while disabled");
    AST_CELL_LEN: assert property (@(posedge core_clk) disable iff (rst)
        (rx_rpos_q <= ucp_pkg::CELL_LAST) && (tx_wpos_q <= ucp_pkg::CELL_LAST))
        else $error("cell position past last byte");
    AST_LOS: assert property (@(posedge core_clk) disable iff (rst)
        !good_signal |-> seq_los_hold) else $error("fill during lost signal");

endmodule : ucp_cell_port

/* File: test/ucp_atm_model.sv */
// Cell-layer device model on the far side of the octet port
`timescale 1ns/1ps

module ucp_atm_model (
    output logic                       rx_clk,
    output logic                       tx_clk,
    output logic                       rx_en_n,
    output ucp_pkg::ucp_tx_pins_t      tx_in,
    input  wire ucp_pkg::ucp_rx_pins_t rx_out
);
    ucp_pkg::ucp_rx_pins_t got [0:52];

    ////////////////////////////////////////////////////////////////////////////////
    // Free-running link clocks, offset so they never line up
    initial begin
        rx_clk = 1'b0;
        forever #40 rx_clk = ~rx_clk;
    end
    initial begin
        tx_clk = 1'b0;
        #17;
        forever #40 tx_clk = ~tx_clk;
    end
    initial begin
        rx_en_n = 1'b1;
        tx_in   = '{en_n: 1'b1, soc: 1'b0, parity: 1'b1, data: 8'h00};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Send one cell; bad names the byte whose parity is spoiled, -1 for none
    task automatic send_cell(input logic [7:0] base, input int bad);
        logic [7:0] d;
        for (int i = 0; i < ucp_pkg::CELL_BYTES; i++) begin
            d = base + 8'(i);
            @(posedge tx_clk);
            tx_in.en_n   <= 1'b0;
            tx_in.soc    <= (i == 0);
            tx_in.parity <= ~^d ^ (i == bad);
            tx_in.data   <= d;
        end
        @(posedge tx_clk);
        tx_in.en_n   <= 1'b1;
        tx_in.soc    <= 1'b0;
        tx_in.parity <= 1'b1;
        tx_in.data   <= ~d; // Idle bus must not keep showing the last byte
    endtask : send_cell

    // Take one cell; sampled mid-period, well after the port updates
    task automatic recv_cell();
        @(posedge rx_clk);
        rx_en_n <= 1'b0;
        @(negedge rx_clk);
        for (int n = 0; n < 40 && rx_out.soc !== 1'b1; n++) @(negedge rx_clk);
        for (int i = 0; i < 53; i++) begin
            got[i] = rx_out;
            if (i < 52) @(negedge rx_clk);
        end
        @(posedge rx_clk);
        rx_en_n <= 1'b1;
    endtask : recv_cell
endmodule : ucp_atm_model

/* File: test/testbench.sv */
// Self-checking bench for the cell-side octet port
`timescale 1ns/1ps

module testbench;
    logic                  core_clk, rst, rx_clk, tx_clk, rx_en_n, rx_clav, tx_clav;
    logic                  good_signal, par_check_en, line_rx_valid, line_rx_ready;
    logic                  line_tx_valid, line_tx_ready, tx_par_err;
    logic [7:0]            line_rx_data;
    ucp_pkg::ucp_rx_pins_t rx_out;
    ucp_pkg::ucp_tx_pins_t tx_in;
    ucp_pkg::ucp_byte_t    line_tx_byte;
    ucp_pkg::ucp_byte_t    txq [$];
    int                    bad_count, compares, perr_seen;

    ucp_cell_port ucp_cell_port_i (.core_clk(core_clk), .rst(rst), .rx_clk_pin(rx_clk),
        .rx_en_n(rx_en_n), .rx_out(rx_out), .rx_clav(rx_clav), .tx_clk_pin(tx_clk),
        .tx_in(tx_in), .tx_clav(tx_clav), .good_signal(good_signal),
        .par_check_en(par_check_en), .line_rx_valid(line_rx_valid),
        .line_rx_data(line_rx_data), .line_rx_ready(line_rx_ready),
        .line_tx_valid(line_tx_valid), .line_tx_byte(line_tx_byte),
        .line_tx_ready(line_tx_ready), .tx_par_err(tx_par_err));
    ucp_atm_model ucp_atm_model_i (.rx_clk(rx_clk), .tx_clk(tx_clk), .rx_en_n(rx_en_n),
        .tx_in(tx_in), .rx_out(rx_out));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // Count parity flags and collect bytes leaving toward the line
    always @(posedge core_clk) begin
        if (tx_par_err === 1'b1) perr_seen++;
        if (line_tx_valid === 1'b1 && line_tx_ready === 1'b1) txq.push_back(line_tx_byte);
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : chk

    task automatic test_done();
        $display("compares %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done

    // Line-side writes; ready may drop, so each byte is held until taken
    task automatic line_put(input logic [7:0] base, input int n);
        for (int i = 0; i < n; i++) begin
            line_rx_valid <= 1'b1;
            line_rx_data  <= base + 8'(i);
            do @(posedge core_clk); while (line_rx_ready !== 1'b1);
        end
        line_rx_valid <= 1'b0;
    endtask : line_put

    // Wait for a buffered cell, pull it over the link and check every byte
    task automatic rx_and_check(input logic [7:0] base);
        logic [7:0] d;
        for (int k = 0; k < 50 && rx_clav !== 1'b1; k++) @(posedge core_clk);
        chk(16'(rx_clav), 16'h0001);
        ucp_atm_model_i.recv_cell();
        for (int i = 0; i < 53; i++) begin
            d = base + 8'(i);
            chk({6'h00, ucp_atm_model_i.got[i]}, {6'h00, i == 0, ~^d, d});
        end
    endtask : rx_and_check

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk(16'({rx_clav, tx_clav, line_tx_valid, tx_par_err}), 16'h0004);
        chk(16'(rx_out), 16'h0100);
    endtask : t_reset

    task automatic t_rx_cell();
        line_put(8'h10, 52);
        repeat (8) @(posedge core_clk);
        chk(16'(rx_clav), 16'h0000);
        line_put(8'h44, 1);
        rx_and_check(8'h10);
        repeat (8) @(posedge core_clk);
        chk(16'(rx_clav), 16'h0000);
    endtask : t_rx_cell

    task automatic t_good_sig();
        line_put(8'h60, 30);
        good_signal <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk(16'({line_rx_ready, rx_clav}), 16'h0000);
        good_signal <= 1'b1;
        @(posedge core_clk);
        line_put(8'hA0, 53);
        rx_and_check(8'hA0);
    endtask : t_good_sig

    task automatic t_tx();
        logic [7:0] bs [3] = '{8'h20, 8'h80, 8'hC0};
        par_check_en <= 1'b1;
        ucp_atm_model_i.send_cell(bs[0], -1);
        ucp_atm_model_i.send_cell(bs[1], 5);
        repeat (20) @(posedge core_clk);
        chk(16'({tx_clav, 8'(perr_seen)}), 16'h0101);
        par_check_en <= 1'b0;
        ucp_atm_model_i.send_cell(bs[2], 7);
        repeat (20) @(posedge core_clk);
        chk(16'({tx_clav, 8'(perr_seen)}), 16'h0001);
        line_tx_ready <= 1'b1;
        for (int k = 0; k < 400 && txq.size() < 159; k++) @(posedge core_clk);
        line_tx_ready <= 1'b0;
        chk(16'(txq.size()), 16'h009F);
        for (int i = 0; i < txq.size() && i < 159; i++)
            chk(16'(txq[i]), {7'h00, i % 53 == 0, bs[i / 53] + 8'(i % 53)});
        repeat (4) @(posedge core_clk);
        chk(16'(tx_clav), 16'h0001);
    endtask : t_tx

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst           = 1'b1;
        good_signal   = 1'b1;
        par_check_en  = 1'b0;
        line_rx_valid = 1'b0;
        line_rx_data  = 8'h00;
        line_tx_ready = 1'b0;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_rx_cell();
        t_good_sig();
        t_tx();
        test_done();
    end

    // Cut a hang short well past the expected run of about 23 us
    initial begin
        #150000;
        bad_count++;
        test_done();
    end
endmodule : testbench
